// File: src/ajsm_pkg.sv
/*
   Shared types and constants for the per-attribute applicant and
   registrar state machines of one bridge port on a backbone segment.
   Assumes a single 10 MHz system clock and a synchronous reset.
*/
package ajsm_pkg;

   // Attribute table size
   localparam int          ajsm_attr_count = 16;
   localparam int          ajsm_attr_width = 4;
   localparam logic [3:0]  ajsm_attr_last  = 4'hF;
   localparam logic [3:0]  ajsm_attr_first = 4'h0;

   // Join time and its cycle count
   localparam int          ajsm_clock_period_ns = 100;
   localparam int          ajsm_join_time_us    = 200000;
   localparam int          ajsm_join_cycles     =
      (ajsm_join_time_us * 1000) / ajsm_clock_period_ns;
   localparam logic [31:0] ajsm_timer_reset     = 32'h0000_0000;

   // Applicant states, one-hot
   typedef enum logic [4:0] {
      very_anxious_observer = 5'h01,
      very_anxious_passive  = 5'h02,
      very_anxious_active   = 5'h04,
      anxious_active        = 5'h08,
      quiet_active          = 5'h10
   } ajsm_app_type;

   // Registrar states, one-hot
   typedef enum logic [1:0] {
      registrar_empty = 2'h1,
      registered      = 2'h2
   } ajsm_reg_type;

   typedef struct packed {
      ajsm_app_type app;
      ajsm_reg_type regs;
   } ajsm_entry_type;

   localparam ajsm_entry_type ajsm_entry_reset = '{very_anxious_observer, registrar_empty};

   // Events from the application and from the receive path
   typedef enum logic [1:0] {
      ev_req_join      = 2'h0,
      ev_rx_join_empty = 2'h1,
      ev_rx_join_in    = 2'h2,
      ev_rx_empty      = 2'h3
   } ajsm_ev_type;

   typedef struct packed {
      ajsm_ev_type kind;
      logic [3:0]  attr;
   } ajsm_cmd_type;

   // Messages handed to the transmit path
   typedef enum logic {
      msg_join_empty = 1'h0,
      msg_join_in    = 1'h1
   } ajsm_msg_type;

   typedef struct packed {
      ajsm_msg_type kind;
      logic [3:0]   attr;
   } ajsm_tx_type;

   localparam ajsm_cmd_type ajsm_cmd_reset = '{ev_req_join, 4'h0};
   localparam ajsm_tx_type  ajsm_tx_reset  = '{msg_join_empty, 4'h0};

   // Sequencer states, one-hot
   typedef enum logic [4:0] {
      st_init       = 5'h01,
      st_idle       = 5'h02,
      st_apply      = 5'h04,
      st_scan_read  = 5'h08,
      st_scan_apply = 5'h10
   } ajsm_seq_type;

endpackage

// File: src/ajsm_table.sv
/*
   Attribute state table: one entry per attribute, one write port and
   one read port whose data come out of a register one cycle later.
   Assumes the caller never needs a write forwarded to a same-cycle read.
*/
`timescale 1ns/100ps
module ajsm_table
(
   // Clock and reset
   input  wire logic                     clock,
   input  wire logic                     nrst,
   // Write port
   input  wire logic                     wen,
   input  wire logic [3:0]               waddr,
   input  wire ajsm_pkg::ajsm_entry_type wdata,
   // Read port
   input  wire logic [3:0]               raddr,
   output      ajsm_pkg::ajsm_entry_type rdata
);
   import ajsm_pkg::*;

   typedef struct packed {
      ajsm_entry_type [ajsm_attr_count-1:0] mem;
      ajsm_entry_type                       rd;
   } ajsm_table_state_type;

   ajsm_table_state_type state;
   ajsm_table_state_type next_state;

   // Contents are not reset here; the sequencer sweeps them after reset
   always_comb
   begin
      next_state    = state;
      next_state.rd = state.mem[raddr];
      if (wen)
      begin
         next_state.mem[waddr] = wdata;
      end
      if (!nrst)
      begin
         next_state.rd = ajsm_entry_reset;
      end
   end

   always_ff @(posedge clock)
   begin
      state <= next_state;
   end

   assign rdata = state.rd;

endmodule // ajsm_table

// File: src/ajsm_core.sv
/*
   Applicant and registrar state machines for every attribute of one
   bridge port. Takes join requests and received messages as events,
   and at each transmission opportunity, one join time apart, walks the
   table and emits JoinEmpty or JoinIn messages.
   Assumes the event source holds an event until it is taken and the
   transmit path accepts every message pulse.
*/
// Functional notes
// R1: Join request in observer goes very-anxious passive
// R2: Opportunity, passive, empty registrar: send JoinEmpty
// R3: JoinEmpty registers; observer applicant keeps its state
// R4: Registered registrar makes the join a JoinIn
// R5: JoinIn in anxious active: go quiet, register
// R6: Anxious active repeats its join, then quiet
// R7: Repeat join comes one join time later
// R8: JoinEmpty in anxious active, empty: very anxious
// R9: Further JoinIn in quiet active changes nothing
// R10: After second join nothing more is sent
// R11: Empty message makes a member very anxious
// R12: Reset: observer, registrar empty, nothing pending
`timescale 1ns/100ps
module ajsm_core
#(
   parameter int join_cycles = ajsm_pkg::ajsm_join_cycles
)
(
   // Clock and reset
   input  wire logic                   clock,
   input  wire logic                   nrst,
   // Event channel
   input  wire logic                   cmd_valid,
   input  wire ajsm_pkg::ajsm_cmd_type cmd,
   output      logic                   cmd_ready,
   // Transmit messages
   output      logic                   tx_valid,
   output      ajsm_pkg::ajsm_tx_type  tx,
   // New registration indication
   output      logic                   join_ind_valid,
   output      logic [3:0]             join_ind_attr
);
   import ajsm_pkg::*;

   typedef struct packed {
      ajsm_seq_type seq;
      logic [3:0]   idx;
      logic [31:0]  timer;
      logic         scan_pending;
      logic         ready;
      ajsm_cmd_type cur;
      logic         tx_valid;
      ajsm_tx_type  tx;
      logic         ind_valid;
      logic [3:0]   ind_attr;
   } ajsm_core_state_type;

   localparam ajsm_core_state_type core_reset = '{
      seq:          st_init,
      idx:          ajsm_attr_first,
      timer:        ajsm_timer_reset,
      scan_pending: 1'b0,
      ready:        1'b0,
      cur:          ajsm_cmd_reset,
      tx_valid:     1'b0,
      tx:           ajsm_tx_reset,
      ind_valid:    1'b0,
      ind_attr:     4'h0
   };

   ajsm_core_state_type state;
   ajsm_core_state_type next_state;

   logic           tab_wen;
   logic [3:0]     tab_waddr;
   ajsm_entry_type tab_wdata;
   logic [3:0]     tab_raddr;
   ajsm_entry_type tab_rdata;

   // Applicant states that declare at an opportunity
   function automatic logic wants_tx(input ajsm_app_type app);
      return (app == very_anxious_passive) || (app == very_anxious_active) ||
             (app == anxious_active);
   endfunction

   // Join flavour follows the registrar
   function automatic ajsm_msg_type join_kind(input ajsm_reg_type r);
      return (r == registered) ? msg_join_in : msg_join_empty;
   endfunction

   // Event effect on one entry
   function automatic ajsm_entry_type on_event(input ajsm_entry_type e,
                                               input ajsm_ev_type    k);
      ajsm_entry_type n;
      n = e;
      unique case (k)
         ev_req_join:
         begin
            if (e.app == very_anxious_observer)
            begin
               n.app = very_anxious_passive; // R1
            end
         end
         ev_rx_join_empty:
         begin
            n.regs = registered; // R3
            if ((e.app == anxious_active) && (e.regs == registrar_empty))
            begin
               n.app = very_anxious_active; // R8
            end
         end
         ev_rx_join_in:
         begin
            n.regs = registered; // R5
            if (e.app == anxious_active)
            begin
               n.app = quiet_active; // R5
            end
            // Quiet active stays where it is
         end // R9
         ev_rx_empty:
         begin
            if ((e.app == anxious_active) || (e.app == quiet_active))
            begin
               n.app = very_anxious_active; // R11
            end
         end
      endcase
      return n;
   endfunction

   // Opportunity effect on one entry
   function automatic ajsm_entry_type on_opportunity(input ajsm_entry_type e);
      ajsm_entry_type n;
      n = e;
      if (e.app == anxious_active)
      begin
         n.app = quiet_active; // R6
      end
      else if (wants_tx(e.app))
      begin
         n.app = anxious_active; // R2
      end
      return n;
   endfunction

   ajsm_table u_table
   (
      .clock (clock),
      .nrst  (nrst),
      .wen   (tab_wen),
      .waddr (tab_waddr),
      .wdata (tab_wdata),
      .raddr (tab_raddr),
      .rdata (tab_rdata)
   );

   // Read address: the event's attribute while idle, else the scan index
   assign tab_raddr = (state.seq == st_idle) ? cmd.attr : state.idx;

   always_comb
   begin
      next_state           = state;
      next_state.tx_valid  = 1'b0;
      next_state.ind_valid = 1'b0;
      tab_wen              = 1'b0;
      tab_waddr            = state.idx;
      tab_wdata            = ajsm_entry_reset;

      // Opportunities fall one join time apart, so a repeat join trails the first by that much
      if (state.timer == 32'(join_cycles - 1))
      begin
         next_state.timer = ajsm_timer_reset;
      end
      else
      begin
         next_state.timer = state.timer + 32'h0000_0001;
      end

      unique case (state.seq)
         st_init:
         begin
            tab_wen   = 1'b1;
            tab_waddr = state.idx;
            tab_wdata = ajsm_entry_reset; // R12
            next_state.idx = state.idx + 4'h1;
            if (state.idx == ajsm_attr_last)
            begin
               next_state.seq = st_idle;
               next_state.idx = ajsm_attr_first;
            end
         end
         st_idle:
         begin
            if (state.scan_pending)
            begin
               next_state.scan_pending = 1'b0;
               next_state.idx          = ajsm_attr_first;
               next_state.seq          = st_scan_read; // R7
            end
            else if (cmd_valid && state.ready)
            begin
               next_state.cur = cmd;
               next_state.seq = st_apply;
            end
         end
         st_apply:
         begin
            tab_wen   = 1'b1;
            tab_waddr = state.cur.attr;
            tab_wdata = on_event(tab_rdata, state.cur.kind);
            if ((tab_rdata.regs == registrar_empty) && (tab_wdata.regs == registered))
            begin
               next_state.ind_valid = 1'b1;
               next_state.ind_attr  = state.cur.attr;
            end
            next_state.seq = st_idle;
         end
         st_scan_read:
         begin
            next_state.seq = st_scan_apply;
         end
         st_scan_apply:
         begin
            tab_wen   = 1'b1;
            tab_waddr = state.idx;
            tab_wdata = on_opportunity(tab_rdata); // R10
            if (wants_tx(tab_rdata.app))
            begin
               next_state.tx_valid = 1'b1;
               next_state.tx.kind  = join_kind(tab_rdata.regs); // R4
               next_state.tx.attr  = state.idx; // R2
            end
            next_state.idx = state.idx + 4'h1;
            next_state.seq = st_scan_read;
            if (state.idx == ajsm_attr_last)
            begin
               next_state.idx = ajsm_attr_first;
               next_state.seq = st_idle;
            end
         end
      endcase

      // An expiry that lands as a scan starts is kept, not lost
      if (state.timer == 32'(join_cycles - 1))
      begin
         next_state.scan_pending = 1'b1;
      end

      // Ready only when the next cycle can take an event
      // The idle cycle that closes a scan stays refused, so no take meets the last pulse
      next_state.ready = (next_state.seq == st_idle) && !next_state.scan_pending &&
                         (state.seq != st_scan_apply);

      if (!nrst)
      begin
         next_state = core_reset; // R12
      end
   end

   always_ff @(posedge clock)
   begin
      state <= next_state;
   end

   assign cmd_ready      = state.ready;
   assign tx_valid       = state.tx_valid;
   assign tx             = state.tx;
   assign join_ind_valid = state.ind_valid;
   assign join_ind_attr  = state.ind_attr;

endmodule // ajsm_core

// File: verif/ajsm_core_assertions.sv
/*
   Port checker for ajsm_core, bound to every instance.
   Assumes one clock and nrst as a synchronous reset.
*/
`timescale 1ns/100ps
module ajsm_core_assertions
#(
   parameter int join_cycles = 64
)
(
   // Clock and reset
   input wire logic                   clock,
   input wire logic                   nrst,
   // Ports watched
   input wire logic                   cmd_valid,
   input wire ajsm_pkg::ajsm_cmd_type cmd,
   input wire logic                   cmd_ready,
   input wire logic                   tx_valid,
   input wire ajsm_pkg::ajsm_tx_type  tx,
   input wire logic                   join_ind_valid,
   input wire logic [3:0]             join_ind_attr
);
   import ajsm_pkg::*;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   a_init_quiet: assert property ($rose(nrst) |->
      (!cmd_ready && !tx_valid && !join_ind_valid)[*8]) else $error("busy after reset");
   a_take_gap: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
      else $error("ready stayed up after take");
   a_ind_cause: assert property (join_ind_valid |-> $past(cmd_valid && cmd_ready, 2))
      else $error("registration without event");
   a_ind_attr: assert property (join_ind_valid |-> join_ind_attr == $past(cmd.attr, 2))
      else $error("registration attribute wrong");
   a_ind_kind: assert property (join_ind_valid |->
      $past(cmd.kind, 2) inside {ev_rx_join_empty, ev_rx_join_in}) else $error("bad cause");
   a_tx_scan: assert property (tx_valid |-> !cmd_ready)
      else $error("message outside scan");
   a_tx_pulse: assert property (tx_valid |=> !tx_valid)
      else $error("message pulse too long");
   a_tx_order: assert property (tx_valid ##2 tx_valid |->
      tx.attr == $past(tx.attr, 2) + 4'h1) else $error("scan order wrong");
endmodule // ajsm_core_assertions

bind ajsm_core ajsm_core_assertions #(.join_cycles(join_cycles)) u_chk
(
   .clock(clock), .nrst(nrst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
   .tx_valid(tx_valid), .tx(tx), .join_ind_valid(join_ind_valid),
   .join_ind_attr(join_ind_attr)
);

// File: verif/ajsm_peer.sv
/*
   Peer bridge model: offers received messages and requests as events.
   Assumes the block takes an event on an edge where ready is high.
*/
`timescale 1ns/100ps
module ajsm_peer
(
   // Clock and handshake
   input  wire logic                   clock,
   input  wire logic                   cmd_ready,
   // Event offered
   output      logic                   cmd_valid,
   output      ajsm_pkg::ajsm_cmd_type cmd
);
   import ajsm_pkg::*;
   initial
   begin
      cmd_valid = 1'b0;
      cmd = ajsm_cmd_reset;
   end
   task automatic send(input ajsm_ev_type k, input logic [3:0] a, output logic ok);
      ok = 1'b0;
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd <= '{k, a};
      for (int n = 0; n < 200 && !ok; n++)
      begin
         @(negedge clock);
         ok = (cmd_ready === 1'b1);
      end
      @(posedge clock);
      cmd_valid <= 1'b0;
      // Released lines change so stale values never look valid
      cmd <= ajsm_cmd_type'(~cmd);
   endtask
endmodule // ajsm_peer

// File: verif/attribute_join_state_machines_tb.sv
/*
   Testbench for ajsm_core: join exchanges with a peer bridge.
   Assumes a shortened join time of 64 cycles.
*/
`timescale 1ns/100ps
module attribute_join_state_machines_tb;
   import ajsm_pkg::*;
   localparam int jc = 64;
   logic         clock;
   logic         nrst;
   logic         cmd_valid;
   logic         cmd_ready;
   logic         tx_valid;
   logic         join_ind_valid;
   logic [3:0]   join_ind_attr;
   logic [3:0]   ind_attr;
   ajsm_cmd_type cmd;
   ajsm_tx_type  tx;
   ajsm_tx_type  txq[$];
   int           txt[$];
   int           failures = 0;
   int           compares = 0;
   int           cycle = 0;
   int           inds = 0;

   ajsm_core #(.join_cycles(jc)) dut (.clock(clock), .nrst(nrst), .cmd_valid(cmd_valid),
      .cmd(cmd), .cmd_ready(cmd_ready), .tx_valid(tx_valid), .tx(tx),
      .join_ind_valid(join_ind_valid), .join_ind_attr(join_ind_attr));
   ajsm_peer peer (.clock(clock), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd(cmd));

   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   always @(posedge clock)
   begin
      cycle++;
      if (tx_valid === 1'b1)
      begin
         txq.push_back(tx);
         txt.push_back(cycle);
      end
      if (join_ind_valid === 1'b1)
      begin
         inds++;
         ind_attr = join_ind_attr;
      end
   end

   task automatic chk(input string what, input logic [7:0] exp, got);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic ev(input ajsm_ev_type k, input logic [3:0] a);
      logic ok;
      peer.send(k, a, ok);
      chk("event taken", 8'h1, {7'h0, ok});
   endtask

   task automatic expect_tx(input ajsm_msg_type k, input logic [3:0] a, output int t);
      t = 0;
      repeat (200) if (txq.size() == 0) @(posedge clock);
      chk("tx seen", 8'h1, {7'h0, txq.size() != 0});
      if (txq.size() != 0)
      begin
         chk("tx", {3'h0, k, a}, {3'h0, txq.pop_front()});
         t = txt.pop_front();
      end
   endtask

   task automatic no_tx(input int n);
      repeat (n) @(posedge clock);
      chk("tx none", 8'h0, 8'(txq.size()));
   endtask

   task automatic s_lost_first;
      int t0;
      int t1;
      ev(ev_req_join, 4'h3);
      expect_tx(msg_join_empty, 4'h3, t0);
      expect_tx(msg_join_empty, 4'h3, t1);
      chk("repeat gap", 8'(jc), 8'(t1 - t0));
      no_tx(150);
   endtask

   task automatic s_peer_first;
      int t;
      ev(ev_rx_join_empty, 4'h5);
      no_tx(150);
      chk("ind attr", 8'h5, {4'h0, ind_attr});
      ev(ev_req_join, 4'h5);
      expect_tx(msg_join_in, 4'h5, t);
      ev(ev_rx_join_in, 4'h5);
      no_tx(150);
      ev(ev_rx_join_in, 4'h5);
      no_tx(150);
      chk("ind count", 8'h1, 8'(inds));
   endtask

   task automatic s_both_join;
      int t;
      ev(ev_req_join, 4'h9);
      expect_tx(msg_join_empty, 4'h9, t);
      ev(ev_rx_join_empty, 4'h9);
      expect_tx(msg_join_in, 4'h9, t);
      expect_tx(msg_join_in, 4'h9, t);
      no_tx(150);
      chk("ind attr", 8'h9, {4'h0, ind_attr});
   endtask

   task automatic s_rejoin;
      int t;
      ev(ev_req_join, 4'h7);
      expect_tx(msg_join_empty, 4'h7, t);
      ev(ev_rx_join_in, 4'h7);
      no_tx(150);
      chk("ind attr", 8'h7, {4'h0, ind_attr});
      ev(ev_rx_empty, 4'h7);
      expect_tx(msg_join_in, 4'h7, t);
      expect_tx(msg_join_in, 4'h7, t);
      no_tx(150);
   endtask

   task automatic s_adjacent;
      int t0;
      int t1;
      ev(ev_req_join, 4'hE);
      ev(ev_req_join, 4'hF);
      expect_tx(msg_join_empty, 4'hE, t0);
      expect_tx(msg_join_empty, 4'hF, t1);
      chk("scan gap", 8'h2, 8'(t1 - t0));
      expect_tx(msg_join_empty, 4'hE, t0);
      expect_tx(msg_join_empty, 4'hF, t1);
      chk("repeat scan gap", 8'h2, 8'(t1 - t0));
      no_tx(150);
   endtask

   task automatic conclude;
      $display("Compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clock);
      failures++;
      conclude();
   end

   initial
   begin
      nrst = 1'b0;
      repeat (5) @(posedge clock);
      chk("ready in reset", 8'h0, {7'h0, cmd_ready});
      nrst <= 1'b1;
      no_tx(40);
      s_lost_first();
      s_peer_first();
      s_both_join();
      s_rejoin();
      s_adjacent();
      conclude();
   end
endmodule // attribute_join_state_machines_tb
